// file: chan_sel_consts.svh
/*
  Constants for the secure channel selection control: widths, reset values
  and the authentication-device power-off timing.
  Assumes a 100 MHz reference clock; included by bare name.
*/
// Overview of operation
// - Host change power-cycles auth device, one second off, unless emulated
// - Auth device host port kept apart from others
// - Filter list edits accepted from administrator only
// - Two roles kept: user and administrator
// - Only authorized mechanisms switch; key combos ignored
// - Exactly one selection mechanism enabled at once
// - Selected host indicator driven from reset onward
// - Keyboard and mouse always share one host
// - Requests from connected hosts never change selection
`ifndef CHAN_SEL_CONSTS_SVH
`define CHAN_SEL_CONSTS_SVH
// Clock period in picoseconds
`define CLK_PERIOD_PS 10000
// Least auth-device power-off time in milliseconds
`define AUTH_OFF_MS 1000
// Off time in cycles, rounded up
`define AUTH_OFF_CYC ((`AUTH_OFF_MS * 64'd1000000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Host index at reset
`define HOST_RST 2'h0
// Mechanism selection at reset: front-panel buttons
`define MECH_RST 2'h0
// Width of a filter list entry
`define FILT_W 32
`endif

// file: chan_sel_pkg.sv
/*
  Types for the secure channel selection control.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package chan_sel_pkg;
  // Selection mechanisms, one enabled at a time
  typedef enum logic [1:0] {
    MECH_BUTTON = 2'b00,
    MECH_REMOTE = 2'b01,
    MECH_SERIAL = 2'b10
  } mech_t;
  // Privilege roles
  typedef enum logic {
    ROLE_USER = 1'b0,
    ROLE_ADMIN = 1'b1
  } role_t;
  // Power sequence states for the authentication device
  typedef enum logic [1:0] {
    PWR_ON = 2'b00,
    PWR_OFF = 2'b01
  } pwr_state_t;
  // Selection request from one source
  typedef struct packed {
    logic valid;
    logic [1:0] host;
  } sel_req_t;
  // Filter list write request
  typedef struct packed {
    logic valid;
    logic deny;
    logic [31:0] data;
  } filt_req_t;
  // Routing outputs: one host index per peripheral path
  typedef struct packed {
    logic [1:0] kbdHost;
    logic [1:0] mouseHost;
    logic [1:0] authHost;
  } route_t;
endpackage

// file: secure_channel_select_control.sv
/*
  Channel selection control for a secure keyboard/mouse switch. Holds the
  selected host, routes keyboard, mouse and the auth device, drives the
  indicator, power-cycles the auth device on each switch unless emulated, and gates filter
  list edits by role.
  Assumes all request inputs come from pins or foreign logic; all but the
  unused keyComboReq are synchronised here; host-side command inputs are deliberately absent.
*/
`timescale 1ns/10ps
`default_nettype none
`include "chan_sel_consts.svh"
module secure_channel_select_control #(
  parameter int HOSTS = 4,
  parameter longint OFF_CYCLES = `AUTH_OFF_CYC
) (
  // Clock and reset
  input wire logic refClk,
  input wire logic arst_n,
  // Selection sources
  input wire chan_sel_pkg::sel_req_t buttonReq,
  input wire chan_sel_pkg::sel_req_t remoteReq,
  input wire chan_sel_pkg::sel_req_t serialReq,
  input wire chan_sel_pkg::sel_req_t keyComboReq,
  // Administration
  input wire logic adminLogin,
  input wire logic adminLogout,
  input wire chan_sel_pkg::mech_t mechSel,
  input wire logic mechSelValid,
  input wire chan_sel_pkg::filt_req_t filtReq,
  input wire logic authEmulated,
  // Outputs
  output logic [1:0] hostIndicator,
  output chan_sel_pkg::route_t route,
  output logic authPowerEn,
  output logic [31:0] allowList,
  output logic [31:0] denyList,
  output logic filtReject,
  output logic [2:0] mechEnable,
  output logic adminActive
);
  import chan_sel_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers: two flops for every foreign input except the unused keyComboReq
  localparam int SW = 3 * 3 + 3 + 2 + 1 + 34 + 1;
  logic [SW-1:0] syncA_ff;
  logic [SW-1:0] syncB_ff;
  wire [SW-1:0] rawIn = {buttonReq, remoteReq, serialReq, adminLogin, adminLogout,
    mechSelValid, mechSel, authEmulated, filtReq, 1'b0};

  // Two-stage synchroniser
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= rawIn;
      syncB_ff <= syncA_ff;
    end
  end

  // Synchronised fields
  sel_req_t sButton, sRemote, sSerial;
  logic sLogin, sLogout, sMechValid, sEmul, sUnused;
  mech_t sMech;
  filt_req_t sFilt;
  assign {sButton, sRemote, sSerial, sLogin, sLogout, sMechValid, sMech, sEmul,
    sFilt, sUnused} = syncB_ff;

  //////////////////////////////////////////////////////////////////////////
  // Roles
  role_t role_ff;
  // Role tracks login and logout; logout wins
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      role_ff <= ROLE_USER;
    end else if (sLogout) begin
      role_ff <= ROLE_USER;
    end else if (sLogin) begin
      role_ff <= ROLE_ADMIN;
    end
  end
  wire isAdmin = (role_ff == ROLE_ADMIN);

  //////////////////////////////////////////////////////////////////////////
  // Mechanism choice: one enabled at a time, admin only
  mech_t mech_ff;
  wire mechLegal = (sMech != mech_t'(2'b11));
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      mech_ff <= mech_t'(`MECH_RST);
    end else if (sMechValid && isAdmin && mechLegal) begin
      mech_ff <= sMech;
    end
  end

  // One-hot enable of the active mechanism
  function automatic logic [2:0] mech_onehot(input mech_t m);
    unique case (m)
      MECH_BUTTON: mech_onehot = 3'h1;
      MECH_REMOTE: mech_onehot = 3'h2;
      MECH_SERIAL: mech_onehot = 3'h4;
      default: mech_onehot = 3'h1;
    endcase
  endfunction
  wire [2:0] mechOh = mech_onehot(mech_ff);

  //////////////////////////////////////////////////////////////////////////
  // Host selection: only the enabled mechanism is heard
  // Key-combination and host-side requests have no path here
  sel_req_t activeReq;
  assign activeReq = mechOh[0] ? sButton : (mechOh[1] ? sRemote : sSerial);
  wire reqOk = activeReq.valid && (int'(activeReq.host) < HOSTS);
  logic [1:0] host_ff;
  wire hostChange = reqOk && (activeReq.host != host_ff);
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      host_ff <= `HOST_RST;
    end else if (hostChange) begin
      host_ff <= activeReq.host;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Auth device power cycling
  pwr_state_t pwr_ff;
  logic [39:0] offCnt_ff;
  wire [39:0] offLast = 40'(OFF_CYCLES - 1);
  // Start the off period on every switch unless emulated
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_ff <= PWR_ON;
      offCnt_ff <= '0;
    end else begin
      unique case (pwr_ff)
        PWR_ON: begin
          if (hostChange && !sEmul) begin
            pwr_ff <= PWR_OFF;
            offCnt_ff <= '0;
          end
        end
        PWR_OFF: begin
          if (hostChange) begin
            offCnt_ff <= '0; // Restart on a further switch
          end else if (offCnt_ff >= offLast) begin
            pwr_ff <= PWR_ON;
          end else begin
            offCnt_ff <= offCnt_ff + 40'h1;
          end
        end
        default: pwr_ff <= PWR_ON;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Filter lists and registered outputs
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      allowList <= '0;
      denyList <= '0;
      filtReject <= 1'b0;
    end else begin
      filtReject <= sFilt.valid && !isAdmin;
      if (sFilt.valid && isAdmin && !sFilt.deny) begin
        allowList <= sFilt.data;
      end
      if (sFilt.valid && isAdmin && sFilt.deny) begin
        denyList <= sFilt.data;
      end
    end
  end

  // Routing and indicators, all from flops
  always_ff @(posedge refClk or negedge arst_n) begin
    if (!arst_n) begin
      hostIndicator <= `HOST_RST;
      route <= '0;
      authPowerEn <= 1'b0;
      mechEnable <= 3'h1;
      adminActive <= 1'b0;
    end else begin
      hostIndicator <= hostChange ? activeReq.host : host_ff;
      route.kbdHost <= hostChange ? activeReq.host : host_ff;
      route.mouseHost <= hostChange ? activeReq.host : host_ff;
      route.authHost <= hostChange ? activeReq.host : host_ff;
      authPowerEn <= (pwr_ff == PWR_ON) && !(hostChange && !sEmul);
      mechEnable <= mechOh;
      adminActive <= isAdmin;
    end
  end
endmodule
`default_nettype wire

// file: chan_sel_checker.sv
/* Checker for the channel select control.
   Assumes a bind onto the top module ports. */
`timescale 1ns/10ps
`default_nettype none
module chan_sel_checker import chan_sel_pkg::*; #(
  parameter int HOSTS = 4
) (
  input wire logic refClk, arst_n, authEmulated, adminActive, authPowerEn, filtReject,
  input wire sel_req_t buttonReq, remoteReq, serialReq,
  input wire logic [1:0] hostIndicator,
  input wire route_t route,
  input wire logic [31:0] allowList, denyList,
  input wire logic [2:0] mechEnable
);
  default clocking @(posedge refClk); endclocking
  default disable iff (!arst_n);
  property p_tie; route == {3{hostIndicator}}; endproperty
  a_tie: assert property (p_tie) else $error("paths split");
  property p_one; $onehot(mechEnable); endproperty
  a_one: assert property (p_one) else $error("mechanisms not one-hot");
  property p_ind; hostIndicator < HOSTS; endproperty
  a_ind: assert property (p_ind) else $error("indicator out of range");
  property p_cut; $changed(hostIndicator) && !authEmulated |-> !authPowerEn; endproperty
  a_cut: assert property (p_cut) else $error("power kept on switch");
  property p_hold; $fell(authPowerEn) |-> !authPowerEn[*8]; endproperty
  a_hold: assert property (p_hold) else $error("power back too soon");
  property p_src;
    !$past(buttonReq.valid, 3) && !$past(remoteReq.valid, 3) && !$past(serialReq.valid, 3)
      |-> $stable(hostIndicator);
  endproperty
  a_src: assert property (p_src) else $error("switch without request");
  property p_rej; filtReject |-> $stable(allowList) && $stable(denyList); endproperty
  a_rej: assert property (p_rej) else $error("rejected edit applied");
  property p_adm; $changed(allowList) || $changed(denyList) || $changed(mechEnable)
    |-> adminActive || $past(adminActive); endproperty
  a_adm: assert property (p_adm) else $error("edit without admin");
endmodule
bind secure_channel_select_control chan_sel_checker #(.HOSTS(HOSTS)) u_chk (.*);
`default_nettype wire

// file: user_panel.sv
/* Front-panel user model: presses select a host.
   Assumes the caller steps on the same clock. */
`timescale 1ns/10ps
`default_nettype none
module user_panel import chan_sel_pkg::*; (
  input wire logic refClk,
  output var sel_req_t req
);
  initial req = '0;
  // Hold the press long enough for the input sync, then release
  task automatic press(input logic [1:0] h);
    @(posedge refClk);
    req <= {1'b1, h};
    repeat (3) @(posedge refClk);
    req <= {1'b0, ~h};
  endtask
endmodule
`default_nettype wire

// file: tb_secure_channel_select_control.sv
/* Self-checking bench for the channel select control.
   Assumes the checker and panel model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_secure_channel_select_control;
  import chan_sel_pkg::*;
  logic refClk, arst_n, adminLogin, adminLogout, mechSelValid, authEmulated;
  // Latches any reject pulse; cleared only at time zero
  logic rejSeen = 1'b0;
  logic authPowerEn, filtReject, adminActive;
  logic [1:0] hostIndicator, m, s, h, e;
  logic [2:0] mechEnable;
  logic [31:0] allowList, denyList;
  sel_req_t btnReq;
  sel_req_t reqs [4];
  mech_t mechSel;
  filt_req_t filtReq;
  route_t route;
  int n_fail, n_checks, k;
  // Rows: {mechanism, source, host, expected host}
  logic [7:0] rows [8] = '{8'h0A, 8'h1E, 8'h36, 8'h55, 8'h4D, 8'hAF, 8'hE0, 8'h88};
  user_panel u_panel (.refClk, .req(btnReq));
  secure_channel_select_control #(.OFF_CYCLES(20)) u_dut (.refClk, .arst_n,
    .buttonReq(btnReq), .remoteReq(reqs[1]), .serialReq(reqs[2]), .keyComboReq(reqs[3]),
    .adminLogin, .adminLogout, .mechSel, .mechSelValid, .filtReq, .authEmulated,
    .hostIndicator, .route, .authPowerEn, .allowList, .denyList, .filtReject,
    .mechEnable, .adminActive);
  initial begin
    refClk = 0;
    forever #5 refClk = ~refClk;
  end
  always @(posedge refClk) if (filtReject) rejSeen <= 1;
  task automatic cyc(input int n);
    repeat (n) @(posedge refClk);
  endtask
  task automatic chk(input logic [31:0] g, x);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Role change by one-cycle pulse
  task automatic admin(input logic on);
    @(posedge refClk);
    adminLogin <= on;
    adminLogout <= !on;
    cyc(1);
    {adminLogin, adminLogout} <= 2'h0;
    cyc(4);
  endtask
  task automatic drv(input logic [1:0] s, h);
    if (s == 0) u_panel.press(h);
    else begin
      @(posedge refClk);
      reqs[s] <= {1'b1, h};
      cyc(3);
      reqs[s] <= {1'b0, ~h};
    end
  endtask
  initial begin
    {arst_n, adminLogin, adminLogout, mechSelValid, authEmulated} = '0;
    reqs = '{default: '0};
    mechSel = MECH_BUTTON;
    filtReq = '0;
    cyc(6);
    chk(mechEnable, 3'h1);
    chk(hostIndicator, 2'h0);
    arst_n <= 1;
    cyc(2);
    chk(authPowerEn, 32'h1);
    foreach (rows[i]) begin
      {m, s, h, e} = rows[i];
      admin(1);
      mechSel <= mech_t'(m);
      mechSelValid <= 1;
      cyc(3);
      mechSelValid <= 0;
      admin(0);
      drv(s, h);
      cyc(6);
      chk(hostIndicator, e);
      chk(route, {3{e}});
    end
    drv(2, 1);
    cyc(2);
    chk(authPowerEn, 0);
    k = 0;
    while (!authPowerEn && k < 40) begin
      cyc(1);
      k++;
    end
    // Off for OFF_CYCLES+1 cycles: switch edge N+3 to power-on edge N+24
    chk(k, 32'd20);
    chk(authPowerEn, 1);
    if (!authPowerEn) stop_test;
    authEmulated <= 1;
    cyc(4);
    drv(2, 2);
    cyc(6);
    chk({hostIndicator, authPowerEn}, 3'h5);
    filtReq <= {2'h2, 32'hA5A50001};
    cyc(1);
    filtReq <= '0;
    cyc(5);
    chk(rejSeen, 32'h1);
    chk(allowList, 32'h0);
    admin(1);
    chk(adminActive, 32'h1);
    filtReq <= {2'h3, 32'h1234ABCD};
    cyc(1);
    filtReq <= '0;
    cyc(5);
    chk(denyList, 32'h1234ABCD);
    filtReq <= {2'h2, 32'h5A5A0002};
    cyc(1);
    filtReq <= '0;
    cyc(5);
    chk(allowList, 32'h5A5A0002);
    chk(mechEnable, 32'h4);
    stop_test;
  end
endmodule
`default_nettype wire
